// *** rtl/vdsb_status_bank.sv ***
// Purpose: Status register bank of a composite video decoder, read-only except the interrupt status and mask
// Assumes: Status inputs come from decoder logic on aclk
// Notes: AXI4-Lite slave; byte address is four times the register index
//
// Behaviour
// [RULE_01] Luma channel over bit 7, under bit 6
// [RULE_02] Blue channel over bit 5, under bit 4
// [RULE_03] Red channel over bit 3, under 2; 1-0 reserved
// [RULE_04] Colour flag high while burst is detected
// [RULE_05] Top seven phase error bits, once per line
// [RULE_06] Reference register shows full 8-bit signal
// [RULE_07] Part register returns fixed family code
// [RULE_08] Revision register returns silicon revision
// [RULE_09] Phase kill bit after comb failure
// [RULE_10] Comb mode encoded in bits 6-5
// [RULE_11] Adaptive table output in bits 4-0
// [RULE_12] Reserved locations read with no content
// [RULE_13] Separate, demodulate, then scale or convert
// [RULE_14] Simple mode uses notch and bandpass filters
// [RULE_15] Reads never disturb live decoder state
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "vdsb_params.svh"

module vdsb_status_bank
   import vdsb_pkg::*;
#(
   parameter logic [7:0] FAMILY_CODE = `VDSB_FAMILY_CODE, // Arbitrary value
   parameter logic [7:0] SILICON_REV = `VDSB_SILICON_REV, // Arbitrary value
   parameter int ADDR_W = 12
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Live decoder state
   input wire vdsb_status_t dec_status,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Interrupt
   output logic irq
);

   // =======================================================================
   // Elaboration check
   if (ADDR_W < 12)
   begin : g_bad_width
      $error("ADDR_W must reach index 0x101");
   end

   // =======================================================================
   // Live captures
   logic [7:0] range_byte;
   logic [7:0] burst_byte;
   logic [7:0] ref_byte;
   logic [7:0] comb_byte;
   logic [6:0] err_hold;
   logic [7:0] irq_stat;
   logic [7:0] irq_mask;
   logic [7:0] next_stat_set;

   // Range flags sampled each clock, reserved bits forced low
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         range_byte <= `VDSB_RST_BYTE;
      else
         range_byte <= {dec_status.range_flags, 2'b00}; // RULE_01 RULE_02 RULE_03
   end

   // Phase error held between line strobes so a read sees one line's value
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         err_hold <= 7'h00;
      else if (dec_status.line_strobe)
         err_hold <= dec_status.subcarrier_error; // RULE_05
   end

   // Burst byte: colour flag is live, error follows the line hold
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         burst_byte <= `VDSB_RST_BYTE;
      else
         burst_byte <= {dec_status.colour_present_flag, err_hold}; // RULE_04
   end

   // Reference signal passes whole
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ref_byte <= `VDSB_RST_BYTE;
      else
         ref_byte <= dec_status.decoder_reference; // RULE_06
   end

   // Comb adaptation status; upstream pipeline orders separation first,
   // so these fields already reflect the separation stage state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         comb_byte <= `VDSB_RST_BYTE;
      else
         comb_byte <= {dec_status.phase_suppress, // RULE_09
                       dec_status.comb_mode_state, // RULE_10
                       dec_status.adapt_table_out}; // RULE_11 RULE_13 RULE_14
   end

   // =======================================================================
   // Interrupt events: each range flag, loss of colour, phase kill
   always_comb
   begin
      next_stat_set = {dec_status.range_flags,
                       ~dec_status.colour_present_flag,
                       dec_status.phase_suppress};
   end

   // =======================================================================
   // Write channel: both halves taken together, one write at a time
   logic wr_offer;
   logic wr_go;
   logic [9:0] wr_idx;
   logic wr_hit_stat;
   logic wr_hit_mask;

   always_comb
   begin
      wr_offer = awvalid && wvalid && !awready && !bvalid;
      wr_go = awvalid && wvalid && awready && wready;
      wr_idx = awaddr[11:2];
      wr_hit_stat = wr_go && wstrb[0] && (wr_idx == `VDSB_IDX_IRQ_STAT);
      wr_hit_mask = wr_go && wstrb[0] && (wr_idx == `VDSB_IDX_IRQ_MASK);
   end

   // Ready pulses a cycle after both valids; the response only follows
   // the handshake, so it never runs ahead of it, and stands until bready
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `VDSB_RESP_OKAY;
      end
      else
      begin
         awready <= wr_offer;
         wready <= wr_offer;
         if (wr_go)
         begin
            bvalid <= 1'b1;
            bresp <= (wr_idx == `VDSB_IDX_IRQ_STAT ||
                      wr_idx == `VDSB_IDX_IRQ_MASK) ?
                     `VDSB_RESP_OKAY : `VDSB_RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // Sticky status: a new event wins over a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_stat <= `VDSB_RST_BYTE;
      else if (wr_hit_stat)
         irq_stat <= (irq_stat & ~wdata[7:0]) | next_stat_set;
      else
         irq_stat <= irq_stat | next_stat_set;
   end

   // Mask register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_mask <= `VDSB_RST_MASK;
      else if (wr_hit_mask)
         irq_mask <= wdata[7:0];
   end

   // Interrupt level straight from a flip-flop
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(irq_stat & irq_mask);
   end

   // =======================================================================
   // Read channel
   vdsb_rd_state_t rd_state;
   logic [9:0] rd_idx;
   logic [7:0] rd_byte;

   // Decode is pure selection; nothing is cleared by a read
   always_comb
   begin
      rd_idx = araddr[11:2];
      rd_byte = 8'h00; // RULE_12
      case (rd_idx)
         `VDSB_IDX_RANGE: rd_byte = range_byte;
         `VDSB_IDX_BURST: rd_byte = burst_byte;
         `VDSB_IDX_REF: rd_byte = ref_byte;
         `VDSB_IDX_PART: rd_byte = FAMILY_CODE; // RULE_07
         `VDSB_IDX_REV: rd_byte = SILICON_REV; // RULE_08
         `VDSB_IDX_COMB: rd_byte = comb_byte;
         `VDSB_IDX_IRQ_STAT: rd_byte = irq_stat;
         `VDSB_IDX_IRQ_MASK: rd_byte = irq_mask;
         default: rd_byte = 8'h00;
      endcase
   end

   // Ready offered a cycle after arvalid; data answered after the
   // handshake and held until rready
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state <= VDSB_RD_IDLE;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `VDSB_RESP_OKAY;
      end
      else
      begin
         arready <= 1'b0;
         case (rd_state)
            VDSB_RD_IDLE:
            begin
               if (arvalid && arready)
               begin
                  rvalid <= 1'b1;
                  rdata <= {24'h000000, rd_byte}; // RULE_15
                  rresp <= `VDSB_RESP_OKAY;
                  rd_state <= VDSB_RD_RESP;
               end
               else if (arvalid)
                  arready <= 1'b1;
            end
            VDSB_RD_RESP:
            begin
               if (rready)
               begin
                  rvalid <= 1'b0;
                  rd_state <= VDSB_RD_IDLE;
               end
            end
            default: rd_state <= VDSB_RD_IDLE;
         endcase
      end
   end

   // =======================================================================
   // Assertions
   property p_range_map;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> range_byte == {$past(dec_status.range_flags), 2'b00};
   endproperty
   a_range_map: assert property (p_range_map) // RULE_01
      else $error("range flags misplaced");

   property p_reserved_low;
      @(posedge aclk) disable iff (!aresetn)
      range_byte[1:0] == 2'b00;
   endproperty
   a_reserved_low: assert property (p_reserved_low) // RULE_03
      else $error("reserved range bits set");

   property p_err_line;
      @(posedge aclk) disable iff (!aresetn)
      !dec_status.line_strobe |=> $stable(err_hold);
   endproperty
   a_err_line: assert property (p_err_line) // RULE_05
      else $error("phase error moved without line strobe");

   property p_err_take;
      @(posedge aclk) disable iff (!aresetn)
      dec_status.line_strobe |=> err_hold == $past(dec_status.subcarrier_error);
   endproperty
   a_err_take: assert property (p_err_take) // RULE_05
      else $error("phase error not taken at line strobe");

   property p_colour;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> burst_byte[`VDSB_BIT_COLOUR] ==
         $past(dec_status.colour_present_flag);
   endproperty
   a_colour: assert property (p_colour) // RULE_04
      else $error("colour flag not shown");

   property p_ref;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> ref_byte == $past(dec_status.decoder_reference);
   endproperty
   a_ref: assert property (p_ref) // RULE_06
      else $error("reference byte wrong");

   property p_part;
      @(posedge aclk) disable iff (!aresetn)
      arvalid && arready && rd_state == VDSB_RD_IDLE &&
      rd_idx == `VDSB_IDX_PART |=> rdata[7:0] == FAMILY_CODE;
   endproperty
   a_part: assert property (p_part) // RULE_07
      else $error("family code wrong");

   property p_rev;
      @(posedge aclk) disable iff (!aresetn)
      arvalid && arready && rd_state == VDSB_RD_IDLE &&
      rd_idx == `VDSB_IDX_REV |=> rdata[7:0] == SILICON_REV;
   endproperty
   a_rev: assert property (p_rev) // RULE_08
      else $error("silicon revision wrong");

   property p_comb;
      @(posedge aclk) disable iff (!aresetn)
      1'b1 |=> comb_byte[`VDSB_BIT_PHASE_SUPPRESS] == $past(dec_status.phase_suppress)
         && comb_byte[6:5] == $past(dec_status.comb_mode_state)
         && comb_byte[4:0] == $past(dec_status.adapt_table_out);
   endproperty
   a_comb: assert property (p_comb) // RULE_10
      else $error("comb byte wrong");

   property p_rsvd;
      @(posedge aclk) disable iff (!aresetn)
      arvalid && arready && rd_state == VDSB_RD_IDLE &&
      rd_idx == `VDSB_IDX_RSVA |=> rdata == 32'h0000_0000;
   endproperty
   a_rsvd: assert property (p_rsvd) // RULE_12
      else $error("reserved read not zero");

   property p_rvalid_hold;
      @(posedge aclk) disable iff (!aresetn)
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_rvalid_hold: assert property (p_rvalid_hold) // RULE_15
      else $error("read answer dropped");

   // Event bits: a new event must land even when a clear arrives with it
   property p_range_event;
      @(posedge aclk) disable iff (!aresetn)
      dec_status.range_flags != 6'h00 |=>
         (irq_stat[7:2] & $past(dec_status.range_flags)) ==
         $past(dec_status.range_flags);
   endproperty
   a_range_event: assert property (p_range_event) // RULE_01
      else $error("range event not latched");

   property p_colour_loss;
      @(posedge aclk) disable iff (!aresetn)
      !dec_status.colour_present_flag |=> irq_stat[1];
   endproperty
   a_colour_loss: assert property (p_colour_loss) // RULE_04
      else $error("colour loss event not latched");

   property p_phase_suppress_event;
      @(posedge aclk) disable iff (!aresetn)
      dec_status.phase_suppress |=> irq_stat[0];
   endproperty
   a_phase_suppress_event: assert property (p_phase_suppress_event) // RULE_09
      else $error("phase kill event not latched");

endmodule // vdsb_status_bank

`default_nettype wire

// *** inc/vdsb_params.svh ***
// Purpose: Offsets, field positions and reset values of the status bank
// Assumes: Included by the design file and the bench
// Notes: Printed offsets are not all multiples of four, so each is kept
//        as a register index; the byte address is four times the index
`ifndef VDSB_PARAMS_SVH
`define VDSB_PARAMS_SVH

// ==========================================================================
// Register indexes; interrupt registers sit above the reserved map so
// every index up to 0xff stays read-only
`define VDSB_IDX_RANGE 10'h043
`define VDSB_IDX_BURST 10'h044
`define VDSB_IDX_REF 10'h045
`define VDSB_IDX_PART 10'h046
`define VDSB_IDX_REV 10'h047
`define VDSB_IDX_RSVA 10'h048
`define VDSB_IDX_COMB 10'h04b
`define VDSB_IDX_RSVB 10'h04c
`define VDSB_IDX_IRQ_STAT 10'h100
`define VDSB_IDX_IRQ_MASK 10'h101

// ==========================================================================
// Field positions
`define VDSB_BIT_COLOUR 7
`define VDSB_BIT_PHASE_SUPPRESS 7
`define VDSB_LSB_COMB 5

// ==========================================================================
// Reset values and identity codes (arbitrary neutral values)
`define VDSB_FAMILY_CODE 8'h5a
`define VDSB_SILICON_REV 8'h01
`define VDSB_RST_BYTE 8'h00
`define VDSB_RST_MASK 8'h00

// ==========================================================================
// Bus answer codes
`define VDSB_RESP_OKAY 2'b00
`define VDSB_RESP_SLVERR 2'b10

`endif

// *** inc/vdsb_pkg.sv ***
// Purpose: Types shared by the status bank
// Assumes: Parameters header on the include path
// Notes: Constants live in the header, types here
package vdsb_pkg;

   // ========================================================================
   // Live decoder state entering the bank
   typedef struct packed {
      logic [5:0] range_flags;    // Luma, blue, red: over then under
      logic colour_present_flag;
      logic [6:0] subcarrier_error;
      logic line_strobe;          // One pulse per video line
      logic [7:0] decoder_reference;
      logic phase_suppress;
      logic [1:0] comb_mode_state;
      logic [4:0] adapt_table_out;
   } vdsb_status_t;

   // Comb mode codes
   typedef enum logic [1:0] {
      VDSB_COMB_FULL3 = 2'b00,
      VDSB_COMB_LOW3 = 2'b01,
      VDSB_COMB_UP3 = 2'b10,
      VDSB_COMB_TWO = 2'b11
   } vdsb_comb_t;

   // Read channel states
   typedef enum logic [0:0] {
      VDSB_RD_IDLE = 1'b0,
      VDSB_RD_RESP = 1'b1
   } vdsb_rd_state_t;

endpackage

// *** tb/vdsb_status_bank_bench.sv ***
// Purpose: Self-checking bench for the video decoder status bank
// Assumes: AXI4-Lite slave; tasks wait for each handshake, no fixed latency
// Notes: Random live status from a fixed seed, plus corner cases
`timescale 1ns/1ps
`default_nettype none
`include "vdsb_params.svh"

module vdsb_status_bank_bench
   import vdsb_pkg::*;
;

   // =======================================================================
   // Signals and counters
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   vdsb_status_t st = '0;
   vdsb_status_t r;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   logic [6:0] perr;
   logic [9:0] ridx [7] = '{10'h043, 10'h044, 10'h045, 10'h046, 10'h047,
                            10'h048, 10'h04b};
   logic [7:0] rexp [7] = '{8'h00, 8'h00, 8'h00, `VDSB_FAMILY_CODE,
                            `VDSB_SILICON_REV, 8'h00, 8'h00};
   logic [9:0] rsvd [7] = '{10'h048, 10'h049, 10'h04a, 10'h04c, 10'h050,
                            10'h051, 10'h0ff};
   int fail_count = 0;
   int num_checks = 0;

   // 100 MHz clock
   always #5 aclk = ~aclk;

   vdsb_status_bank vdsb_status_bank_inst (
      .aclk(aclk), .aresetn(aresetn), .dec_status(st),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .irq(irq)
   );

   // =======================================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Read one register; waits for rvalid under a bound
   task automatic rd_reg(input logic [9:0] idx);
      int n;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      check("read wait", 32'(n < 50), 32'h1);
      rd = rdata;
      resp = rresp;
      arvalid <= 1'b0;
      rready <= 1'b0;
   endtask

   // Write one register; address and data offered together
   task automatic wr_reg(input logic [9:0] idx, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      check("write wait", 32'(n < 50), 32'h1);
      resp = bresp;
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b0;
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog, far beyond the expected run of a few hundred cycles
   initial
   begin
      #200us;
      fail_count++;
      complete_run;
   end

   // =======================================================================
   // Main sequence
   initial
   begin
      void'($urandom(54));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // Values after reset, identity bytes included
      for (int i = 0; i < 7; i++)
      begin
         rd_reg(ridx[i]);
         check("reset value", rd, {24'h0, rexp[i]});
         check("read resp", 32'(resp), 32'(`VDSB_RESP_OKAY));
      end
      $display("test reset done");
      // Live status fields, every comb mode
      for (int i = 0; i < 16; i++)
      begin
         r = vdsb_status_t'(31'($urandom));
         r.line_strobe = 1'b0;
         r.comb_mode_state = 2'(i);
         @(posedge aclk);
         st <= r;
         repeat (2) @(posedge aclk);
         rd_reg(`VDSB_IDX_RANGE);
         check("range", rd, {24'h0, r.range_flags, 2'b00});
         rd_reg(`VDSB_IDX_BURST);
         check("colour", 32'(rd[7]), 32'(r.colour_present_flag));
         rd_reg(`VDSB_IDX_REF);
         check("reference", rd, {24'h0, r.decoder_reference});
         rd_reg(`VDSB_IDX_COMB);
         check("comb", rd, {24'h0, r.phase_suppress, r.comb_mode_state,
               r.adapt_table_out});
         rd_reg(`VDSB_IDX_RANGE);
         check("no side effect", rd, {24'h0, r.range_flags, 2'b00});
      end
      $display("test live status done");
      // Phase error taken only at the line pulse
      for (int k = 0; k < 3; k++)
      begin
         perr = (k == 0) ? 7'h7f : (k == 1) ? 7'h00 : 7'($urandom);
         r.subcarrier_error = perr;
         r.line_strobe = 1'b1;
         @(posedge aclk);
         st <= r;
         r.line_strobe = 1'b0;
         r.subcarrier_error = ~perr;
         @(posedge aclk);
         st <= r;
         repeat (3) @(posedge aclk);
         rd_reg(`VDSB_IDX_BURST);
         check("phase error", 32'(rd[6:0]), 32'(perr));
      end
      $display("test phase error done");
      // Reserved reads and refused writes
      foreach (rsvd[i])
      begin
         rd_reg(rsvd[i]);
         check("reserved", rd, 32'h0);
      end
      wr_reg(`VDSB_IDX_PART, 8'hff);
      check("write resp", 32'(resp), 32'(`VDSB_RESP_SLVERR));
      rd_reg(`VDSB_IDX_PART);
      check("family", rd, {24'h0, `VDSB_FAMILY_CODE});
      $display("test reserved done");
      // Interrupt: raise, mask, clear
      r = '0;
      r.colour_present_flag = 1'b1;
      @(posedge aclk);
      st <= r;
      repeat (2) @(posedge aclk);
      wr_reg(`VDSB_IDX_IRQ_MASK, 8'h00);
      wr_reg(`VDSB_IDX_IRQ_STAT, 8'hff);
      rd_reg(`VDSB_IDX_IRQ_STAT);
      check("irq status clear", rd, 32'h0);
      r.range_flags = 6'h20;
      @(posedge aclk);
      st <= r;
      r.range_flags = 6'h00;
      @(posedge aclk);
      st <= r;
      repeat (3) @(posedge aclk);
      rd_reg(`VDSB_IDX_IRQ_STAT);
      check("irq status set", rd, 32'h80);
      check("irq masked", 32'(irq), 32'h0);
      wr_reg(`VDSB_IDX_IRQ_MASK, 8'h80);
      repeat (3) @(posedge aclk);
      check("irq raised", 32'(irq), 32'h1);
      wr_reg(`VDSB_IDX_IRQ_STAT, 8'h80);
      repeat (3) @(posedge aclk);
      check("irq cleared", 32'(irq), 32'h0);
      rd_reg(`VDSB_IDX_IRQ_MASK);
      check("irq mask", rd, 32'h80);
      $display("test interrupt done");
      complete_run;
   end

endmodule // vdsb_status_bank_bench

`default_nettype wire
